// *** rtl/pfm_pkg.sv ***
package pfm_pkg;

	localparam int NUM_PADS = 23;
	localparam int CODE_W = 4;
	localparam int GPIO_W = 51;
	localparam int N_PO = 54;
	localparam int N_PI = 36;

	// function select codes
	localparam logic [3:0] CODE_GPIO = 4'h0;
	localparam logic [3:0] CODE_ALT1 = 4'h1;
	localparam logic [3:0] CODE_ALT2 = 4'h2;
	localparam logic [3:0] CODE_ALT3 = 4'h3;
	localparam logic [3:0] CODE_ALT4 = 4'h4;
	localparam logic [3:0] CODE_DEBUG = 4'h5;
	localparam logic [3:0] CODE_ALT6 = 4'h6;
	localparam logic [3:0] CODE_EINT = 4'h7;

	// pad index within the pad vectors
	localparam logic [4:0] PAD_CLK = 5'h00;
	localparam logic [4:0] PAD_CMD = 5'h01;
	localparam logic [4:0] PAD_D0 = 5'h02;
	localparam logic [4:0] PAD_D1 = 5'h03;
	localparam logic [4:0] PAD_D2 = 5'h04;
	localparam logic [4:0] PAD_D3 = 5'h05;
	localparam logic [4:0] PAD_B1 = 5'h07;
	localparam logic [4:0] PAD_B2 = 5'h08;
	localparam logic [4:0] PAD_B3 = 5'h09;
	localparam logic [4:0] PAD_B4 = 5'h0A;
	localparam logic [4:0] PAD_B7 = 5'h0D;
	localparam logic [4:0] PAD_B8 = 5'h0E;
	localparam logic [4:0] PAD_B9 = 5'h0F;
	localparam logic [4:0] PAD_B10 = 5'h10;
	localparam logic [4:0] PAD_T1 = 5'h13;
	localparam logic [4:0] PAD_T3 = 5'h14;
	localparam logic [4:0] PAD_KROW = 5'h15;
	localparam logic [4:0] PAD_KCOL = 5'h16;

	// general-purpose I/O numbering
	localparam logic [5:0] GPIO_CARD_BASE = 6'h06;
	localparam logic [5:0] GPIO_T1 = 6'h2A;
	localparam logic [5:0] GPIO_T3 = 6'h2C;
	localparam logic [5:0] GPIO_KROW = 6'h30;
	localparam logic [5:0] GPIO_KCOL = 6'h32;

	// route kinds: bit1 drives the pad, bit0 senses it
	localparam logic [1:0] K_NONE = 2'h0;
	localparam logic [1:0] K_IN = 2'h1;
	localparam logic [1:0] K_OUT = 2'h2;
	localparam logic [1:0] K_BIDIR = 2'h3;
	localparam logic [5:0] IDX_NONE = 6'h3F;
	localparam logic [4:0] SLOT_NONE = 5'h1F;

	// peripheral sources that can drive a pad
	localparam logic [5:0] PO_SPI0_CK = 6'h00;
	localparam logic [5:0] PO_SPI0_CS = 6'h01;
	localparam logic [5:0] PO_SPI0_DO = 6'h02;
	localparam logic [5:0] PO_U0_RTS = 6'h03;
	localparam logic [5:0] PO_U0_TX = 6'h04;
	localparam logic [5:0] PO_SPI1_CK = 6'h05;
	localparam logic [5:0] PO_SPI1_DO = 6'h06;
	localparam logic [5:0] PO_SPI1_CS = 6'h07;
	localparam logic [5:0] PO_AU_BCK = 6'h08;
	localparam logic [5:0] PO_AU_WCK = 6'h09;
	localparam logic [5:0] PO_AU_MCK = 6'h0A;
	localparam logic [5:0] PO_AU_DAT = 6'h0B;
	localparam logic [5:0] PO_TW_CLK = 6'h0C;
	localparam logic [5:0] PO_TW_DAT = 6'h0D;
	localparam logic [5:0] PO_CON_TX = 6'h0E;
	localparam logic [5:0] PO_CX_WACT = 6'h0F;
	localparam logic [5:0] PO_PWM3 = 6'h10;
	localparam logic [5:0] PO_PWM5 = 6'h11;
	localparam logic [5:0] PO_SD_CMD = 6'h12;
	localparam logic [5:0] PO_SD_D0 = 6'h13;
	localparam logic [5:0] PO_WD_DAT = 6'h17;
	localparam logic [5:0] PO_CX_PRI = 6'h18;
	localparam logic [5:0] PO_DBG0 = 6'h19;
	localparam logic [5:0] PO_ANT0 = 6'h29;

	// peripheral inputs fed from a pad
	localparam logic [5:0] PI_SD_CLK = 6'h00;
	localparam logic [5:0] PI_SD_CMD = 6'h01;
	localparam logic [5:0] PI_SD_D0 = 6'h02;
	localparam logic [5:0] PI_SPI0_DI = 6'h06;
	localparam logic [5:0] PI_U0_CTS = 6'h07;
	localparam logic [5:0] PI_U0_RX = 6'h08;
	localparam logic [5:0] PI_SPI1_DI = 6'h09;
	localparam logic [5:0] PI_TW_DAT = 6'h0A;
	localparam logic [5:0] PI_CX_FREQ = 6'h0B;
	localparam logic [5:0] PI_CX_ACT = 6'h0C;
	localparam logic [5:0] PI_CX_PRI = 6'h0D;
	localparam logic [5:0] PI_WD_CLK = 6'h0E;
	localparam logic [5:0] PI_WD_DAT = 6'h0F;
	localparam logic [5:0] PI_CON_RX = 6'h10;
	localparam logic [5:0] PI_EINT0 = 6'h11;

	// per-pad slots, pad 22 first
	localparam logic [NUM_PADS-1:0][4:0] PAD_DBG = {5'h1F, 5'h1F, 5'h1F,
		5'h1F, 5'h1F, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h1F, 5'h1F, 5'h0B, 5'h0A,
		5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
	localparam logic [NUM_PADS-1:0][4:0] PAD_ANT = {5'h0B, 5'h09, 5'h05,
		5'h03, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h1F, 5'h1F, 5'h1F, 5'h08, 5'h07,
		5'h06, 5'h05, 5'h04, 5'h03, 5'h1F, 5'h1F, 5'h03, 5'h02, 5'h01, 5'h00};
	localparam logic [NUM_PADS-1:0][4:0] PAD_EINT = {5'h1F, 5'h1F, 5'h12,
		5'h01, 5'h10, 5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08,
		5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00, 5'h01, 5'h00};

	// reset values
	localparam logic [NUM_PADS-1:0][3:0] SEL_RST = {4'h1, 4'h1, 4'h2, 4'h2,
		{19{4'h1}}};
	localparam logic [NUM_PADS-1:0] DIR_RST = 23'h443140;
	localparam logic [NUM_PADS-1:0] PULL_UP_RST = 23'h6498FE;
	localparam logic [NUM_PADS-1:0] PULL_DN_RST = 23'h196701;

endpackage

// *** rtl/pfm_pad_mux.sv ***
`timescale 1ns/10ps
module pfm_pad_mux (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] cfg_pad_in,
	input wire logic [3:0] cfg_code_in,
	input wire logic sel_wr_en_in,
	input wire logic pull_wr_en_in,
	input wire logic pull_up_wr_in,
	input wire logic pull_down_wr_in,
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_in_in,
	input wire logic chip_reset_pad_n_in,
	input wire logic [pfm_pkg::GPIO_W-1:0] gpio_dout_in,
	input wire logic [pfm_pkg::GPIO_W-1:0] gpio_oe_in,
	input wire logic spi_master0_clock_in,
	input wire logic spi_master0_select_in,
	input wire logic spi_master0_data_out_in,
	input wire logic serial0_request_in,
	input wire logic serial0_transmit_in,
	input wire logic spi_master1_clock_in,
	input wire logic spi_master1_data_out_in,
	input wire logic spi_master1_select_in,
	input wire logic audio_out_bit_clock_in,
	input wire logic audio_out_word_clock_in,
	input wire logic audio_out_master_clock_in,
	input wire logic audio_out_data_in,
	input wire logic two_wire0_clock_in,
	input wire logic two_wire0_data_drv_in,
	input wire logic two_wire0_data_oe_in,
	input wire logic console_serial_transmit_in,
	input wire logic coexist_wireless_active_in,
	input wire logic pwm_channel3_in,
	input wire logic pwm_channel5_in,
	input wire logic sd_slave_cmd_drv_in,
	input wire logic sd_slave_cmd_oe_in,
	input wire logic [3:0] sd_slave_data_drv_in,
	input wire logic [3:0] sd_slave_data_oe_in,
	input wire logic wire_debug_data_drv_in,
	input wire logic wire_debug_data_oe_in,
	input wire logic coexist_priority_drv_in,
	input wire logic coexist_priority_oe_in,
	input wire logic [15:0] debug_bus_in,
	input wire logic [12:0] antenna_select_in,
	output logic [pfm_pkg::NUM_PADS-1:0] pad_out_out,
	output logic [pfm_pkg::NUM_PADS-1:0] pad_oe_out,
	output logic [pfm_pkg::NUM_PADS-1:0] pad_pull_up_out,
	output logic [pfm_pkg::NUM_PADS-1:0] pad_pull_down_out,
	output logic [pfm_pkg::NUM_PADS*4-1:0] function_select_code_out,
	output logic chip_reset_out,
	output logic chip_reset_pull_up_out,
	output logic [pfm_pkg::GPIO_W-1:0] gpio_din_out,
	output logic sd_slave_clock_out,
	output logic sd_slave_cmd_out,
	output logic [3:0] sd_slave_data_out,
	output logic spi_master0_data_in_out,
	output logic serial0_clear_out,
	output logic serial0_receive_out,
	output logic spi_master1_data_in_out,
	output logic two_wire0_data_out,
	output logic coexist_frequency_in_out,
	output logic coexist_active_in_out,
	output logic coexist_priority_out,
	output logic wire_debug_clock_out,
	output logic wire_debug_data_out,
	output logic console_serial_receive_out,
	output logic [18:0] external_interrupt_line_out
);

	localparam int NP = pfm_pkg::NUM_PADS;

	logic [NP-1:0][3:0] sel_ff;
	logic [NP-1:0] pull_up_ff;
	logic [NP-1:0] pull_dn_ff;
	logic [NP-1:0] pad_out_ff;
	logic [NP-1:0] pad_oe_ff;
	logic [pfm_pkg::N_PI-1:0] pi_ff;
	logic [pfm_pkg::GPIO_W-1:0] gpio_din_ff;
	logic chip_rst_ff;
	logic chip_pu_ff;

	logic [NP-1:0] nxt_pad_out;
	logic [NP-1:0] nxt_pad_oe;
	logic [NP-1:0] sense;
	logic [NP-1:0] gpio_sel;
	logic [NP-1:0][5:0] pi_idx;
	logic [NP-1:0][5:0] gpio_idx;
	logic [pfm_pkg::N_PI-1:0] nxt_pi;
	logic [pfm_pkg::GPIO_W-1:0] nxt_gpio_din;

	// fixed I/O number of a pad in general-purpose mode
	function automatic logic [5:0] fn_gpio_num(input logic [4:0] p);
		logic [5:0] n;
		case (p)
			pfm_pkg::PAD_T1: n = pfm_pkg::GPIO_T1;
			pfm_pkg::PAD_T3: n = pfm_pkg::GPIO_T3;
			pfm_pkg::PAD_KROW: n = pfm_pkg::GPIO_KROW;
			pfm_pkg::PAD_KCOL: n = pfm_pkg::GPIO_KCOL;
			default: n = pfm_pkg::GPIO_CARD_BASE + {1'b0, p};
		endcase
		return n;
	endfunction

	// {kind, source index, sink index} for a pad under a code
	function automatic logic [13:0] fn_route(input logic [4:0] p,
		input logic [3:0] c);
		logic [4:0] dbg;
		logic [4:0] ant;
		logic [4:0] ein;
		logic [3:0] ecode;
		logic [13:0] r;
		dbg = pfm_pkg::PAD_DBG[p];
		ant = pfm_pkg::PAD_ANT[p];
		ein = pfm_pkg::PAD_EINT[p];
		// card clock and command carry their interrupt on 0100
		ecode = (p == pfm_pkg::PAD_CLK || p == pfm_pkg::PAD_CMD) ?
			pfm_pkg::CODE_ALT4 : pfm_pkg::CODE_EINT;
		r = {pfm_pkg::K_NONE, pfm_pkg::IDX_NONE, pfm_pkg::IDX_NONE};
		if (c == pfm_pkg::CODE_DEBUG && dbg != pfm_pkg::SLOT_NONE) begin
			r = {pfm_pkg::K_OUT, pfm_pkg::PO_DBG0 + {1'b0, dbg},
				pfm_pkg::IDX_NONE};
		end
		if (c == pfm_pkg::CODE_ALT6 && ant != pfm_pkg::SLOT_NONE) begin
			r = {pfm_pkg::K_OUT, pfm_pkg::PO_ANT0 + {1'b0, ant},
				pfm_pkg::IDX_NONE};
		end
		if (c == ecode && ein != pfm_pkg::SLOT_NONE) begin
			r = {pfm_pkg::K_IN, pfm_pkg::IDX_NONE,
				pfm_pkg::PI_EINT0 + {1'b0, ein}};
		end
		case ({p, c})
			{pfm_pkg::PAD_CLK, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_SD_CLK};
			{pfm_pkg::PAD_CMD, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_SD_CMD, pfm_pkg::PI_SD_CMD};
			{pfm_pkg::PAD_D0, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SD_D0, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D1, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_SD_D0 + 6'h01, pfm_pkg::PI_SD_D0 + 6'h01};
			{pfm_pkg::PAD_D2, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_SD_D0 + 6'h02, pfm_pkg::PI_SD_D0 + 6'h02};
			{pfm_pkg::PAD_D3, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_SD_D0 + 6'h03, pfm_pkg::PI_SD_D0 + 6'h03};
			{pfm_pkg::PAD_T1, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_WD_CLK};
			{pfm_pkg::PAD_T3, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_WD_DAT, pfm_pkg::PI_WD_DAT};
			{pfm_pkg::PAD_KROW, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_CON_RX};
			{pfm_pkg::PAD_KCOL, pfm_pkg::CODE_ALT1}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_CON_TX, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_CLK, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI0_CK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_CMD, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI0_CS, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D0, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_SPI0_DI};
			{pfm_pkg::PAD_D1, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI0_DO, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D0, pfm_pkg::CODE_ALT4}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_U0_RTS, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D1, pfm_pkg::CODE_ALT4}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_U0_CTS};
			{pfm_pkg::PAD_D2, pfm_pkg::CODE_ALT4}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_U0_RX};
			{pfm_pkg::PAD_D3, pfm_pkg::CODE_ALT4}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_U0_TX, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D2, pfm_pkg::CODE_ALT6}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_TW_CLK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D3, pfm_pkg::CODE_ALT6}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_TW_DAT, pfm_pkg::PI_TW_DAT};
			{pfm_pkg::PAD_B7, pfm_pkg::CODE_ALT6}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_CX_FREQ};
			{pfm_pkg::PAD_B8, pfm_pkg::CODE_ALT6}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_CX_ACT};
			{pfm_pkg::PAD_B9, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_BIDIR,
				pfm_pkg::PO_CX_PRI, pfm_pkg::PI_CX_PRI};
			{pfm_pkg::PAD_B10, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_CX_WACT, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B1, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI1_CK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B2, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI1_DO, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B3, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_IN,
				pfm_pkg::IDX_NONE, pfm_pkg::PI_SPI1_DI};
			{pfm_pkg::PAD_B4, pfm_pkg::CODE_ALT2}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_SPI1_CS, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B1, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_AU_BCK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B2, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_AU_WCK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_B3, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_AU_MCK, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_D3, pfm_pkg::CODE_ALT3}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_AU_DAT, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_KROW, pfm_pkg::CODE_DEBUG}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_PWM3, pfm_pkg::IDX_NONE};
			{pfm_pkg::PAD_KCOL, pfm_pkg::CODE_DEBUG}: r = {pfm_pkg::K_OUT,
				pfm_pkg::PO_PWM5, pfm_pkg::IDX_NONE};
			default: r = r;
		endcase
		return r;
	endfunction

	// every peripheral source gathered by index
	wire [pfm_pkg::N_PO-1:0] po = {antenna_select_in, debug_bus_in,
		coexist_priority_drv_in, wire_debug_data_drv_in, sd_slave_data_drv_in,
		sd_slave_cmd_drv_in, pwm_channel5_in, pwm_channel3_in,
		coexist_wireless_active_in, console_serial_transmit_in,
		two_wire0_data_drv_in, two_wire0_clock_in, audio_out_data_in,
		audio_out_master_clock_in, audio_out_word_clock_in,
		audio_out_bit_clock_in, spi_master1_select_in, spi_master1_data_out_in,
		spi_master1_clock_in, serial0_transmit_in, serial0_request_in,
		spi_master0_data_out_in, spi_master0_select_in, spi_master0_clock_in};
	// enables matter only for two-way functions; one-way outputs always drive
	wire [pfm_pkg::N_PO-1:0] po_oe = {29'h1FFFFFFF, coexist_priority_oe_in,
		wire_debug_data_oe_in, sd_slave_data_oe_in, sd_slave_cmd_oe_in, 4'hF,
		two_wire0_data_oe_in, 13'h1FFF};

	// pad numbers past the last pad are dropped without any indication
	wire cfg_hit = cfg_pad_in < 5'(NP);

	for (genvar p = 0; p < NP; p++) begin : g_pad
		wire [13:0] rt = fn_route(5'(p), sel_ff[p]);
		wire [1:0] kind = rt[13:12];
		wire drv = kind[1];
		// idle routes point at source 0 so no read falls past the vector
		wire [5:0] po_i = drv ? rt[11:6] : 6'h00;
		wire [5:0] gi = fn_gpio_num(5'(p));
		assign gpio_sel[p] = sel_ff[p] == pfm_pkg::CODE_GPIO;
		assign gpio_idx[p] = gi;
		assign sense[p] = kind[0];
		assign pi_idx[p] = rt[5:0];
		// a reserved code yields kind none: no drive, no sense
		assign nxt_pad_out[p] = gpio_sel[p] ? gpio_dout_in[gi] :
			(drv & po[po_i]);
		assign nxt_pad_oe[p] = gpio_sel[p] ? gpio_oe_in[gi] :
			(drv & (~kind[0] | po_oe[po_i]));
	end

	// interrupt lines reachable from two or three pads are ored together
	always_comb begin
		nxt_pi = '0;
		nxt_gpio_din = '0;
		for (int p = 0; p < NP; p++) begin
			if (sense[p]) begin
				nxt_pi[pi_idx[p]] = nxt_pi[pi_idx[p]] | pad_in_in[p];
			end
			if (gpio_sel[p]) begin
				nxt_gpio_din[gpio_idx[p]] = pad_in_in[p];
			end
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sel_ff <= pfm_pkg::SEL_RST;
		end else if (sel_wr_en_in && cfg_hit) begin
			sel_ff[cfg_pad_in] <= cfg_code_in;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pull_up_ff <= pfm_pkg::PULL_UP_RST;
			pull_dn_ff <= pfm_pkg::PULL_DN_RST;
		end else if (pull_wr_en_in && cfg_hit) begin
			pull_up_ff[cfg_pad_in] <= pull_up_wr_in;
			pull_dn_ff[cfg_pad_in] <= pull_down_wr_in;
		end
	end

	// registered pad side costs one cycle but keeps outputs glitch free
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pad_out_ff <= '0;
			pad_oe_ff <= pfm_pkg::DIR_RST;
			pi_ff <= '0;
			gpio_din_ff <= '0;
		end else begin
			pad_out_ff <= nxt_pad_out;
			pad_oe_ff <= nxt_pad_oe;
			pi_ff <= nxt_pi;
			gpio_din_ff <= nxt_gpio_din;
		end
	end

	// reset pad bypasses the selectors entirely
	// its pull-up is fixed on: the pad has no pull control of its own
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chip_rst_ff <= 1'b1;
			chip_pu_ff <= 1'b1;
		end else begin
			chip_rst_ff <= ~chip_reset_pad_n_in;
			chip_pu_ff <= 1'b1;
		end
	end

	assign pad_out_out = pad_out_ff;
	assign pad_oe_out = pad_oe_ff;
	assign pad_pull_up_out = pull_up_ff;
	assign pad_pull_down_out = pull_dn_ff;
	assign function_select_code_out = sel_ff;
	assign chip_reset_out = chip_rst_ff;
	assign chip_reset_pull_up_out = chip_pu_ff;
	assign gpio_din_out = gpio_din_ff;
	assign sd_slave_clock_out = pi_ff[pfm_pkg::PI_SD_CLK];
	assign sd_slave_cmd_out = pi_ff[pfm_pkg::PI_SD_CMD];
	assign sd_slave_data_out = pi_ff[pfm_pkg::PI_SD_D0 +: 4];
	assign spi_master0_data_in_out = pi_ff[pfm_pkg::PI_SPI0_DI];
	assign serial0_clear_out = pi_ff[pfm_pkg::PI_U0_CTS];
	assign serial0_receive_out = pi_ff[pfm_pkg::PI_U0_RX];
	assign spi_master1_data_in_out = pi_ff[pfm_pkg::PI_SPI1_DI];
	assign two_wire0_data_out = pi_ff[pfm_pkg::PI_TW_DAT];
	assign coexist_frequency_in_out = pi_ff[pfm_pkg::PI_CX_FREQ];
	assign coexist_active_in_out = pi_ff[pfm_pkg::PI_CX_ACT];
	assign coexist_priority_out = pi_ff[pfm_pkg::PI_CX_PRI];
	assign wire_debug_clock_out = pi_ff[pfm_pkg::PI_WD_CLK];
	assign wire_debug_data_out = pi_ff[pfm_pkg::PI_WD_DAT];
	assign console_serial_receive_out = pi_ff[pfm_pkg::PI_CON_RX];
	assign external_interrupt_line_out = pi_ff[pfm_pkg::PI_EINT0 +: 19];

endmodule // pfm_pad_mux

// *** verif/pfm_pad_mux_properties.sv ***
`timescale 1ns/10ps
module pfm_pad_mux_properties (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] cfg_pad_in,
	input wire logic [3:0] cfg_code_in,
	input wire logic sel_wr_en_in,
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_in_in,
	input wire logic chip_reset_pad_n_in,
	input wire logic [pfm_pkg::GPIO_W-1:0] gpio_dout_in,
	input wire logic [pfm_pkg::GPIO_W-1:0] gpio_oe_in,
	input wire logic spi_master0_clock_in,
	input wire logic [15:0] debug_bus_in,
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_out_out,
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_oe_out,
	input wire logic [pfm_pkg::NUM_PADS*4-1:0] function_select_code_out,
	input wire logic chip_reset_out,
	input wire logic chip_reset_pull_up_out,
	input wire logic spi_master0_data_in_out,
	input wire logic serial0_receive_out,
	input wire logic [18:0] external_interrupt_line_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	wire [91:0] sel = function_select_code_out;
	property p_sel_write;
		sel_wr_en_in && cfg_pad_in < 5'h17 |=>
			sel[$past(cfg_pad_in)*4 +: 4] == $past(cfg_code_in);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("selector write not stored");
	property p_refuse;
		sel_wr_en_in && cfg_pad_in > 5'h16 |=> $stable(sel);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("write to missing pad changed a selector");
	property p_gpio;
		sel[11:8] == 4'h0 |=> pad_oe_out[2] == $past(gpio_oe_in[8]) &&
			pad_out_out[2] == $past(gpio_dout_in[8]);
	endproperty
	a_gpio: assert property (p_gpio)
		else $error("gpio 8 not routed to card data 0");
	property p_spi0_clk;
		sel[3:0] == 4'h3 |=> pad_oe_out[0] &&
			pad_out_out[0] == $past(spi_master0_clock_in);
	endproperty
	a_spi0_clk: assert property (p_spi0_clk)
		else $error("spi 0 clock not on card clock");
	property p_spi0_in;
		sel[11:8] == 4'h3 |=> spi_master0_data_in_out == $past(pad_in_in[2]);
	endproperty
	a_spi0_in: assert property (p_spi0_in)
		else $error("spi 0 data in not from card data 0");
	property p_uart_rx;
		sel[19:16] == 4'h4 |=> serial0_receive_out == $past(pad_in_in[4]);
	endproperty
	a_uart_rx: assert property (p_uart_rx)
		else $error("serial 0 receive not from card data 2");
	property p_debug;
		sel[27:24] == 4'h5 |=> pad_oe_out[6] &&
			pad_out_out[6] == $past(debug_bus_in[6]);
	endproperty
	a_debug: assert property (p_debug)
		else $error("debug bit 6 not on bottom pad 0");
	property p_eint;
		sel[27:24] == 4'h7 |=>
			external_interrupt_line_out[4] == $past(pad_in_in[6]);
	endproperty
	a_eint: assert property (p_eint)
		else $error("bottom pad 0 not on interrupt line 4");
	property p_reserved;
		(sel[11:8] > 4'h7) [*2] |-> !pad_oe_out[2] && !spi_master0_data_in_out;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved code still routes card data 0");
	property p_chip_reset;
		!$past(sys_rst_in) |-> chip_reset_pull_up_out &&
			chip_reset_out == !$past(chip_reset_pad_n_in);
	endproperty
	a_chip_reset: assert property (p_chip_reset)
		else $error("chip reset pad not followed");
	c_write: cover property (sel_wr_en_in && cfg_code_in == 4'h3);
	c_eint: cover property (sel[27:24] == 4'h7 && pad_in_in[6]);
	c_chip_reset: cover property (!chip_reset_pad_n_in);
endmodule // pfm_pad_mux_properties

bind pfm_pad_mux pfm_pad_mux_properties pfm_pad_mux_properties_i (.*);

// *** verif/pfm_board_model.sv ***
`timescale 1ns/10ps
module pfm_board_model (
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_out_in,
	input wire logic [pfm_pkg::NUM_PADS-1:0] pad_oe_in,
	input wire logic [pfm_pkg::NUM_PADS-1:0] ext_drive_in,
	output logic [pfm_pkg::NUM_PADS-1:0] pad_level_out
);
	// a pad the chip drives reads back its own level, else the board wins
	assign pad_level_out = (pad_oe_in & pad_out_in) |
		(~pad_oe_in & ext_drive_in);
endmodule // pfm_board_model

// *** verif/tb_pfm_pad_mux.sv ***
`timescale 1ns/10ps
module tb_pfm_pad_mux;
	logic clock_in;
	logic sys_rst_in = '1, chip_reset_pad_n_in = '1;
	logic [4:0] cfg_pad_in = '0;
	logic [3:0] cfg_code_in = '0;
	logic sel_wr_en_in = '0, pull_wr_en_in = '0, pull_up_wr_in = '0;
	logic pull_down_wr_in = '0, serial0_request_in = '0;
	logic [pfm_pkg::GPIO_W-1:0] gpio_dout_in = '0, gpio_oe_in = '0;
	logic spi_master0_clock_in = '0, spi_master0_select_in = '0;
	logic spi_master0_data_out_in = '0, serial0_transmit_in = '0;
	logic spi_master1_clock_in = '0, spi_master1_data_out_in = '0;
	logic spi_master1_select_in = '0, audio_out_bit_clock_in = '0;
	logic audio_out_word_clock_in = '0, audio_out_master_clock_in = '0;
	logic audio_out_data_in = '0, two_wire0_clock_in = '0;
	logic two_wire0_data_drv_in = '0, two_wire0_data_oe_in = '0;
	logic console_serial_transmit_in = '0, coexist_wireless_active_in = '0;
	logic pwm_channel3_in = '0, pwm_channel5_in = '0;
	logic sd_slave_cmd_drv_in = '0, sd_slave_cmd_oe_in = '0;
	logic [3:0] sd_slave_data_drv_in = '0, sd_slave_data_oe_in = '0;
	logic wire_debug_data_drv_in = '0, wire_debug_data_oe_in = '0;
	logic coexist_priority_drv_in = '0, coexist_priority_oe_in = '0;
	logic [15:0] debug_bus_in = '0;
	logic [12:0] antenna_select_in = '0;
	logic [pfm_pkg::NUM_PADS-1:0] ext_drive = '0, pad_in_in;
	logic [pfm_pkg::NUM_PADS-1:0] pad_out_out, pad_oe_out;
	logic [pfm_pkg::NUM_PADS-1:0] pad_pull_up_out, pad_pull_down_out;
	logic [pfm_pkg::NUM_PADS*4-1:0] function_select_code_out;
	logic [pfm_pkg::GPIO_W-1:0] gpio_din_out;
	logic chip_reset_out, chip_reset_pull_up_out, sd_slave_clock_out;
	logic sd_slave_cmd_out, spi_master0_data_in_out, serial0_clear_out;
	logic serial0_receive_out, spi_master1_data_in_out, two_wire0_data_out;
	logic coexist_frequency_in_out, coexist_active_in_out;
	logic coexist_priority_out, wire_debug_clock_out, wire_debug_data_out;
	logic console_serial_receive_out;
	logic [3:0] sd_slave_data_out;
	logic [18:0] external_interrupt_line_out;
	int err_count = 0, checks_done = 0;
	pfm_pad_mux pfm_pad_mux_i (.*);
	pfm_board_model pfm_board_model_i (.pad_out_in(pad_out_out),
		.pad_oe_in(pad_oe_out), .ext_drive_in(ext_drive),
		.pad_level_out(pad_in_in));
	initial begin
		clock_in = '0;
		forever #4 clock_in = ~clock_in;
	end
	task automatic cmp(input string what, input logic [91:0] exp,
		input logic [91:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic set_code(input logic [4:0] p, input logic [3:0] c);
		@(posedge clock_in);
		cfg_pad_in <= p;
		cfg_code_in <= c;
		sel_wr_en_in <= '1;
		@(posedge clock_in);
		sel_wr_en_in <= '0;
	endtask
	// selector lands after one edge, routed pads after the next
	task automatic settle();
		repeat (3) @(posedge clock_in);
		#1;
	endtask
	task automatic t_reset();
		#1;
		cmp("sel", pfm_pkg::SEL_RST, function_select_code_out);
		cmp("pull up", pfm_pkg::PULL_UP_RST, pad_pull_up_out);
		cmp("pull down", pfm_pkg::PULL_DN_RST, pad_pull_down_out);
		cmp("oe", pfm_pkg::DIR_RST, pad_oe_out);
		cmp("reset pull", 1'h1, chip_reset_pull_up_out);
	endtask
	task automatic t_default();
		ext_drive <= 23'h38002B;
		console_serial_transmit_in <= '1;
		cfg_pad_in <= pfm_pkg::PAD_B3;
		{pull_up_wr_in, pull_down_wr_in} <= 2'h2;
		pull_wr_en_in <= '1;
		@(posedge clock_in);
		pull_wr_en_in <= '0;
		settle();
		cmp("default in", 5'h1F, {sd_slave_clock_out, sd_slave_cmd_out,
			wire_debug_clock_out, wire_debug_data_out,
			console_serial_receive_out});
		cmp("sd data", 4'hA, sd_slave_data_out);
		cmp("console out", 2'h3, {pad_oe_out[22], pad_out_out[22]});
		cmp("pull", 2'h2, {pad_pull_up_out[9], pad_pull_down_out[9]});
	endtask
	task automatic t_gpio();
		set_code(pfm_pkg::PAD_D0, pfm_pkg::CODE_GPIO);
		gpio_oe_in[8] <= '1;
		gpio_dout_in[8] <= '1;
		settle();
		cmp("gpio drive", 2'h3, {pad_oe_out[2], pad_out_out[2]});
		@(posedge clock_in);
		gpio_oe_in[8] <= '0;
		ext_drive[2] <= '1;
		settle();
		cmp("gpio in", 51'h100, gpio_din_out);
	endtask
	task automatic t_spi0();
		for (int p = 0; p < 4; p++) set_code(5'(p), pfm_pkg::CODE_ALT3);
		spi_master0_clock_in <= '1;
		spi_master0_data_out_in <= '1;
		settle();
		cmp("spi0 oe", 4'hB, pad_oe_out[3:0]);
		cmp("spi0 out", 4'h9, pad_out_out[3:0] & 4'hB);
		cmp("spi0 in", 1'h1, spi_master0_data_in_out);
	endtask
	task automatic t_uart();
		for (int p = 2; p < 6; p++) set_code(5'(p), pfm_pkg::CODE_ALT4);
		serial0_request_in <= '1;
		ext_drive[4:3] <= 2'h2;
		settle();
		cmp("uart oe", 4'h9, pad_oe_out[5:2]);
		cmp("uart out", 4'h1, pad_out_out[5:2] & 4'h9);
		cmp("uart in", 2'h2, {serial0_receive_out, serial0_clear_out});
	endtask
	task automatic t_bottom();
		for (int p = 7; p < 11; p++) set_code(5'(p), pfm_pkg::CODE_ALT2);
		spi_master1_clock_in <= '1;
		spi_master1_select_in <= '1;
		ext_drive[9] <= '1;
		settle();
		cmp("spi1 oe", 4'hB, pad_oe_out[10:7]);
		cmp("spi1 out", 4'h9, pad_out_out[10:7] & 4'hB);
		cmp("spi1 in", 1'h1, spi_master1_data_in_out);
		for (int p = 7; p < 10; p++) set_code(5'(p), pfm_pkg::CODE_ALT3);
		set_code(pfm_pkg::PAD_D3, pfm_pkg::CODE_ALT3);
		set_code(pfm_pkg::PAD_B7, pfm_pkg::CODE_ALT6);
		set_code(pfm_pkg::PAD_B8, pfm_pkg::CODE_ALT6);
		set_code(pfm_pkg::PAD_B10, pfm_pkg::CODE_ALT2);
		{audio_out_word_clock_in, audio_out_master_clock_in} <= 2'h3;
		audio_out_data_in <= '1;
		coexist_wireless_active_in <= '1;
		ext_drive[14:13] <= 2'h1;
		settle();
		cmp("audio oe", 4'hF, {pad_oe_out[9:7], pad_oe_out[5]});
		cmp("audio out", 4'hD, {pad_out_out[9:7], pad_out_out[5]});
		cmp("coex in", 2'h2, {coexist_frequency_in_out,
			coexist_active_in_out});
		cmp("coex out", 2'h3, {pad_oe_out[16], pad_out_out[16]});
	endtask
	task automatic t_misc();
		set_code(5'h06, pfm_pkg::CODE_EINT);
		set_code(5'h1F, pfm_pkg::CODE_ALT3);
		ext_drive[6] <= '1;
		settle();
		cmp("eint", 19'h10, external_interrupt_line_out);
		set_code(5'h06, pfm_pkg::CODE_DEBUG);
		set_code(pfm_pkg::PAD_KROW, pfm_pkg::CODE_DEBUG);
		set_code(pfm_pkg::PAD_D0, 4'h8);
		debug_bus_in <= 16'h0040;
		pwm_channel3_in <= '1;
		chip_reset_pad_n_in <= '0;
		settle();
		cmp("debug", 2'h3, {pad_oe_out[6], pad_out_out[6]});
		cmp("pwm3", 2'h3, {pad_oe_out[21], pad_out_out[21]});
		cmp("reserved", 2'h0, {pad_oe_out[2], spi_master0_data_in_out});
		cmp("chip reset", 1'h1, chip_reset_out);
	endtask
	task automatic wrap_up();
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clock_in);
		t_reset();
		@(posedge clock_in);
		sys_rst_in <= '0;
		t_default();
		t_gpio();
		t_spi0();
		t_uart();
		t_bottom();
		t_misc();
		wrap_up();
	end
endmodule // tb_pfm_pad_mux
